/* tlvpg_bench.sv */
// Self-checking bench for the record walker and partition gate
`timescale 1ns/10ps
`default_nettype none
module tlvpg_bench import tlvpg_pkg::*;;
  localparam int unsigned PW = 8;
  localparam int unsigned NR = 4;
  logic ref_clk, arst_n, start, hasVersion, byteVld, byteRdy, hdrVld, valVld, valLast;
  logic verBad, busy, done, err, stall, stallOn, secEnvDbgOff, errRun;
  logic [LEN_W-1:0] seqSize;
  logic [7:0] byteIn, valByte;
  tlvpg_hdr_t hdr;
  tlvpg_ver_t ver;
  logic [NR-1:0][PW-1:0] reqId, crtId;
  logic [NR-1:0] reqVld, reqIsApp, crtVld, grant;
  int numErrors = 0;
  int nTests = 0;
  logic [31:0] rng = 32'h00000004;
  logic [47:0] expHdr[$];
  logic [8:0] expVal[$];

  tlvpg_top #(.PID_W(PW), .NREQ(NR), .NCRT(NR)) DUT (.ref_clk(ref_clk), .arst_n(arst_n),
    .start(start), .hasVersion(hasVersion), .seqSize(seqSize), .byteVld(byteVld),
    .byteIn(byteIn), .byteRdy(byteRdy), .hdrVld(hdrVld), .hdr(hdr), .valVld(valVld),
    .valByte(valByte), .valLast(valLast), .ver(ver), .verBad(verBad), .busy(busy),
    .done(done), .err(err), .reqId(reqId), .reqVld(reqVld), .reqIsApp(reqIsApp),
    .crtId(crtId), .crtVld(crtVld), .secEnvDbgOff(secEnvDbgOff), .grant(grant));

  tlvpg_host_model host (.ref_clk(ref_clk), .arst_n(arst_n), .byteRdy(byteRdy),
    .stall(stall), .byteVld(byteVld), .byteIn(byteIn));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // =========================================================
  // Helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [NR-1:0] gateExp();
    logic [NR-1:0] g;
    logic hit;
    for (int i = 0; i < NR; i++) begin
      hit = 1'b0;
      for (int j = 0; j < NR; j++) begin
        if (crtVld[j] && crtId[j] == reqId[i]) hit = 1'b1;
      end
      g[i] = reqVld[i] && (crtVld == '0 || hit) && !(secEnvDbgOff && reqIsApp[i]);
    end
    return g;
  endfunction

  task automatic chkv(input logic [47:0] act, input logic [47:0] exp, input string what);
    nTests++;
    if (act !== exp) begin
      numErrors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic chkb(input logic act, input logic exp, input string what);
    nTests++;
    if (act !== exp) begin
      numErrors++;
      $display("[FAIL] %0t %s got %b want %b", $time, what, act, exp);
    end
  endtask

  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic addRec(input logic [15:0] typ, input logic [31:0] len, input logic keep);
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      host.push(i < 2 ? 8'h00 : (i < 4 ? typ[8*(i-2) +: 8] : len[8*(i-4) +: 8]));
    end
    if (keep) expHdr.push_back({typ, len});
    for (int i = 0; i < len; i++) begin
      b = 8'(xs());
      host.push(b);
      if (keep) expVal.push_back({i == len - 1, b});
    end
    for (int i = 0; i < (4 - len % 4) % 4; i++) host.push(8'h00);
  endtask

  task automatic pushVer(input logic [15:0] v);
    host.push(v[15:8]);
    host.push(v[7:0]);
    host.push(8'h00);
    host.push(8'h00);
  endtask

  task automatic runWalk(input logic hv, input logic [15:0] v, input logic [31:0] sz,
                         input logic expErr);
    int n;
    if (done === 1'b1 || err === 1'b1) begin
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      @(posedge ref_clk);
    end
    hasVersion <= hv;
    seqSize <= sz;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #2; // After the monitor has popped this edge's pulses
      n++;
    end while (done !== 1'b1 && err !== 1'b1 && n < 3000);
    chkb(err, expErr, "err");
    chkb(done, !expErr, "done");
    if (hv) chkv({32'h00000000, ver}, {32'h00000000, v}, "ver");
    if (hv) chkb(verBad, v[15:8] == 8'h00, "verBad");
    chkv(48'(expHdr.size() + expVal.size()), 48'h000000000000, "left");
    expHdr.delete();
    expVal.delete();
    host.flush();
    @(posedge ref_clk);
  endtask

  task automatic gateOnce(input logic noChain);
    @(posedge ref_clk);
    for (int i = 0; i < NR; i++) begin
      reqId[i] <= 8'(xs() % 6);
      crtId[i] <= 8'(xs() % 6);
    end
    reqVld <= 4'(xs());
    reqIsApp <= 4'(xs());
    crtVld <= noChain ? 4'h0 : 4'(xs());
    secEnvDbgOff <= 1'(xs());
    @(posedge ref_clk);
    #1;
    chkv({44'h00000000000, grant}, {44'h00000000000, gateExp()}, "grant");
  endtask

  // =========================================================
  // Output monitor
  always @(posedge ref_clk) begin
    #1;
    if (hdrVld === 1'b1 && !errRun) begin
      if (expHdr.size() > 0) chkv(hdr, expHdr.pop_front(), "hdr");
      else chkb(1'b1, 1'b0, "extra hdr");
    end
    if (valVld === 1'b1) begin
      if (expVal.size() > 0) chkv({39'h0000000000, valLast, valByte},
                                  {39'h0000000000, expVal.pop_front()}, "val");
      else chkb(1'b1, 1'b0, "extra val");
    end
  end

  // Host stalls only on odd random walks, so it never competes for the seed
  always @(posedge ref_clk) stall <= stallOn ? 1'(xs()) : 1'b0;

  initial begin
    #200000;
    numErrors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tallyAndFinish();
  end

  // =========================================================
  // Main sequence
  initial begin
    logic [15:0] v;
    int sz, len, nrec;
    arst_n = 1'b0;
    start = 1'b0;
    hasVersion = 1'b0;
    seqSize = '0;
    stall = 1'b0;
    stallOn = 1'b0;
    errRun = 1'b0;
    secEnvDbgOff = 1'b0;
    reqId = '0;
    reqVld = '0;
    reqIsApp = '0;
    crtId = '0;
    crtVld = '0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chkb(busy | done | err | hdrVld | valVld, 1'b0, "reset");
    @(posedge ref_clk);
    // Every pad count and a zero-length record
    addRec(16'h0001, 2, 1'b1);
    addRec(16'hABCD, 0, 1'b1);
    addRec(16'h8001, 1, 1'b1);
    addRec(16'h0102, 3, 1'b1);
    addRec(16'h0005, 4, 1'b1);
    runWalk(1'b0, 16'h0000, 56, 1'b0);
    for (int k = 0; k < 6; k++) begin
      v = {8'(1 + xs() % 4), 8'(xs())};
      pushVer(v);
      sz = 4;
      nrec = 1 + xs() % 4;
      for (int r = 0; r < nrec; r++) begin
        len = xs() % 10;
        addRec(16'(xs()), len, 1'b1);
        sz += 8 + (len + 3) / 4 * 4;
      end
      stallOn = k[0];
      runWalk(1'b1, v, sz, 1'b0);
      stallOn = 1'b0;
    end
    pushVer(16'h0003);
    addRec(16'h0001, 2, 1'b1);
    runWalk(1'b1, 16'h0003, 16, 1'b0);
    errRun = 1'b1;
    // Header plus padded value need 20 bytes against 16 declared
    addRec(16'h0009, 9, 1'b0);
    runWalk(1'b0, 16'h0000, 16, 1'b1);
    addRec(16'h0001, 2, 1'b0);
    runWalk(1'b0, 16'h0000, 14, 1'b1);
    errRun = 1'b0;
    for (int k = 0; k < 40; k++) gateOnce(k % 4 == 0);
    tallyAndFinish();
  end
endmodule
`default_nettype wire

/* tlvpg_byte_asm.sv */
// Little-endian byte assembler: builds a word from a byte stream
`timescale 1ns/10ps
`default_nettype none
module tlvpg_byte_asm import tlvpg_pkg::*; #(
  parameter int unsigned NBYTES = 4
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic clear, // Restart assembly
  input wire logic byteVld, // Byte strobe
  input wire logic [7:0] byteIn, // Byte data
  output logic [8*NBYTES-1:0] word, // Assembled word
  output logic full // All bytes collected
);
  typedef struct packed {
    logic [8*NBYTES-1:0] word;
    logic [$clog2(NBYTES+1)-1:0] cnt;
  } tlvpg_asm_t;

  tlvpg_asm_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.cnt = '0;
      st_nxt.word = '0;
    end else if (byteVld && st_r.cnt < NBYTES[$clog2(NBYTES+1)-1:0]) begin
      // Low byte first: each new byte enters at the top, earlier bytes shift down
      st_nxt.word = {byteIn, st_r.word[8*NBYTES-1:8]};
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word = st_r.word;
  assign full = (st_r.cnt == NBYTES[$clog2(NBYTES+1)-1:0]);
endmodule
`default_nettype wire

/* tlvpg_host_model.sv */
// Debug host model: offers a queued byte stream, holding each byte until taken
`timescale 1ns/10ps
`default_nettype none
module tlvpg_host_model (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic byteRdy, // Parser accepts a byte
  input wire logic stall, // Hold off the next byte
  output logic byteVld, // Byte offered
  output logic [7:0] byteIn // Byte data
);
  logic [7:0] q[$];
  logic drop = 1'b0;

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  // Withdraws a stale offer too, so a new stream never inherits it
  task automatic flush();
    q.delete();
    drop = 1'b1;
  endtask

  // =========================================================
  // Offer logic
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      byteVld <= 1'b0;
      byteIn <= 8'h00;
    end else if (drop) begin
      drop = 1'b0;
      byteVld <= 1'b0;
      byteIn <= ~byteIn;
    end else begin
      if (byteVld && byteRdy && q.size() > 0) begin
        void'(q.pop_front());
      end
      if (byteVld && !byteRdy) begin
        byteVld <= 1'b1;
      end else if (q.size() > 0 && !stall) begin
        byteVld <= 1'b1;
        byteIn <= q[0];
      end else begin
        // Idle line toggles so a stale byte never looks valid
        byteVld <= 1'b0;
        byteIn <= ~byteIn;
      end
    end
  end
endmodule
`default_nettype wire

/* tlvpg_part_gate.sv */
// Partition gate: decides grant per requested partition identifier
`timescale 1ns/10ps
`default_nettype none
module tlvpg_part_gate import tlvpg_pkg::*; #(
  parameter int unsigned PID_W = PID_W_DEF, // Identifier width is open
  parameter int unsigned NREQ = PID_N_DEF,
  parameter int unsigned NCRT = PID_N_DEF
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [NREQ-1:0][PID_W-1:0] reqId, // Token request list
  input wire logic [NREQ-1:0] reqVld, // Request entry valid
  input wire logic [NREQ-1:0] reqIsApp, // Entry is application partition
  input wire logic [NCRT-1:0][PID_W-1:0] crtId, // Chain partition list
  input wire logic [NCRT-1:0] crtVld, // Chain entry valid
  input wire logic secEnvDbgOff, // Secure environment debug forbidden
  output logic [NREQ-1:0] grant // Registered grant per request
);
  typedef struct packed {
    logic [NREQ-1:0] grant;
  } tlvpg_gate_t;

  tlvpg_gate_t st_r, st_nxt;
  logic [NREQ-1:0] inChain;
  logic anyChain;

  assign anyChain = |crtVld;

  always_comb begin
    inChain = '0;
    for (int i = 0; i < NREQ; i++) begin
      for (int j = 0; j < NCRT; j++) begin
        if (crtVld[j] && crtId[j] == reqId[i]) begin
          inChain[i] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NREQ; i++) begin
      // Only listed requests qualify chain restricts when non-empty
      st_nxt.grant[i] = reqVld[i] && (!anyChain || inChain[i])
                        && !(secEnvDbgOff && reqIsApp[i]);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign grant = st_r.grant;

  property p_appDenied;
    @(posedge ref_clk) disable iff (!arst_n)
    secEnvDbgOff && reqIsApp[0] |=> !grant[0];
  endproperty
  a_appDenied: assert property (p_appDenied) else $error("app partition granted");

  property p_unrequested;
    @(posedge ref_clk) disable iff (!arst_n)
    !reqVld[0] |=> !grant[0];
  endproperty
  a_unrequested: assert property (p_unrequested) else $error("unrequested partition granted");

  property p_chain;
    @(posedge ref_clk) disable iff (!arst_n)
    anyChain && !inChain[0] |=> !grant[0];
  endproperty
  a_chain: assert property (p_chain) else $error("grant outside chain");

  property p_open;
    @(posedge ref_clk) disable iff (!arst_n)
    !anyChain && reqVld[0] && !(secEnvDbgOff && reqIsApp[0]) |=> grant[0];
  endproperty
  a_open: assert property (p_open) else $error("unconstrained request denied");
endmodule
`default_nettype wire

/* tlvpg_pkg.sv */
// Package: constants and carrier types for the record parser and partition gate
// ====================================================================
// Summary of operation
// - Each record opens with a header holding type identifier and length.
// - First two header bytes are reserved, sent as zero, ignored.
// - Next two header bytes carry the record type identifier.
// - Last four header bytes give value length, padding excluded.
// - Next record starts after header plus length rounded up to four.
// - Walk ends when the declared sequence size is consumed.
// - Record values are flat data, never parsed as nested records.
// - Multi-byte scalars arrive least significant byte first.
// - Untyped arrays arrive low byte first; top byte comes last.
// - Every outer aggregate size is a whole number of words.
// - Version is two bytes: major first, minor second.
// - Version is read from the first member before other members.
// - Versions start at 1.0; major zero is never valid.
// - Token may request zero or more partition identifiers.
// - If chain lists partitions, grant only requested ones found in chain.
// - If chain lists none, grant every requested partition.
// - Deny application partitions when secure environment debug is forbidden.
package tlvpg_pkg;

  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned HDR_BYTES = 8;
  localparam int unsigned LEN_W = 32;
  localparam logic [1:0] ALIGN_MASK = 2'h3;
  localparam logic [7:0] VER_MAJOR_MIN = 8'h01;
  localparam int unsigned PID_W_DEF = 32;
  localparam int unsigned PID_N_DEF = 8;

  typedef enum logic [2:0] {
    TLVPG_IDLE = 3'b000,
    TLVPG_VER = 3'b001,
    TLVPG_HDR0 = 3'b010,
    TLVPG_HDR1 = 3'b011,
    TLVPG_VAL = 3'b100,
    TLVPG_DONE = 3'b101,
    TLVPG_ERR = 3'b110
  } tlvpg_state_t;

  // Record header fields as the parser reports them
  typedef struct packed {
    logic [15:0] typeId;
    logic [31:0] valLen;
  } tlvpg_hdr_t;

  // Version field of an aggregate
  typedef struct packed {
    logic [7:0] major;
    logic [7:0] minor;
  } tlvpg_ver_t;

endpackage

/* tlvpg_top.sv */
// Record sequence walker with version check and partition gate
`timescale 1ns/10ps
`default_nettype none
module tlvpg_top import tlvpg_pkg::*; #(
  parameter int unsigned PID_W = PID_W_DEF,
  parameter int unsigned NREQ = PID_N_DEF,
  parameter int unsigned NCRT = PID_N_DEF
) (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic start, // Begin a sequence walk
  input wire logic hasVersion, // Aggregate opens with a version word
  input wire logic [LEN_W-1:0] seqSize, // Declared sequence size, bytes
  input wire logic byteVld, // Stream byte valid
  input wire logic [7:0] byteIn, // Stream byte
  output logic byteRdy, // Parser accepts a byte
  output logic hdrVld, // Header pulse
  output tlvpg_hdr_t hdr, // Header fields
  output logic valVld, // Value byte pulse (flat data)
  output logic [7:0] valByte, // Value byte
  output logic valLast, // Last real value byte
  output tlvpg_ver_t ver, // Captured version
  output logic verBad, // Version major zero
  output logic busy, // Walk in progress
  output logic done, // Walk finished cleanly
  output logic err, // Overrun or bad alignment
  input wire logic [NREQ-1:0][PID_W-1:0] reqId, // Token partition list
  input wire logic [NREQ-1:0] reqVld, // Token entry valid
  input wire logic [NREQ-1:0] reqIsApp, // Application partition entry
  input wire logic [NCRT-1:0][PID_W-1:0] crtId, // Chain partition list
  input wire logic [NCRT-1:0] crtVld, // Chain entry valid
  input wire logic secEnvDbgOff, // Secure environment debug forbidden
  output logic [NREQ-1:0] grant // Partition grants
);
  // ====================================================================
  // State
  typedef struct packed {
    tlvpg_state_t st;
    logic [LEN_W-1:0] left;
    logic [LEN_W-1:0] valLeft;
    logic [LEN_W-1:0] padLeft;
    logic [1:0] bcnt;
    tlvpg_hdr_t hdr;
    logic hdrVld;
    logic valVld;
    logic valLast;
    logic [7:0] valByte;
    tlvpg_ver_t ver;
    logic verBad;
  } tlvpg_top_st_t;

  tlvpg_top_st_t s_r, s_nxt;
  logic take, asmClr;
  logic [31:0] asmWord;

  assign byteRdy = (s_r.st == TLVPG_VER) || (s_r.st == TLVPG_HDR0)
                   || (s_r.st == TLVPG_HDR1) || (s_r.st == TLVPG_VAL);
  assign take = byteVld && byteRdy;
  assign asmClr = (s_r.st == TLVPG_IDLE) || (take && s_r.bcnt == ALIGN_MASK);

  tlvpg_byte_asm #(.NBYTES(WORD_BYTES)) u_asm (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .clear(asmClr),
    .byteVld(take),
    .byteIn(byteIn),
    .word(asmWord),
    .full()
  );

  // Word is complete on the fourth byte; combine with live byte
  logic [31:0] wordNow;
  assign wordNow = {byteIn, asmWord[31:8]};

  // ====================================================================
  // Walker
  always_comb begin
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] pl;
    len = wordNow;
    pl = (wordNow + LEN_W'(ALIGN_MASK)) & ~LEN_W'(ALIGN_MASK); // Rounded up to a word
    s_nxt = s_r;
    s_nxt.hdrVld = 1'b0;
    s_nxt.valVld = 1'b0;
    s_nxt.valLast = 1'b0;
    if (take) begin
      s_nxt.bcnt = s_r.bcnt + 2'h1;
    end
    unique case (s_r.st)
      TLVPG_IDLE: begin
        s_nxt.bcnt = '0;
        if (start) begin
          s_nxt.left = seqSize;
          s_nxt.verBad = 1'b0;
          if (seqSize[1:0] != 2'h0) begin
            s_nxt.st = TLVPG_ERR; // Outer size must be whole words
          end else if (hasVersion) begin
            s_nxt.st = TLVPG_VER; // Version before any other member
          end else if (seqSize == '0) begin
            s_nxt.st = TLVPG_DONE;
          end else begin
            s_nxt.st = TLVPG_HDR0;
          end
        end
      end
      TLVPG_VER: begin
        if (take && s_r.bcnt == ALIGN_MASK) begin
          // Major in first byte, minor in second
          s_nxt.ver = {wordNow[7:0], wordNow[15:8]};
          s_nxt.verBad = (wordNow[7:0] < VER_MAJOR_MIN);
          s_nxt.left = s_r.left - LEN_W'(WORD_BYTES);
          if (s_r.left < LEN_W'(WORD_BYTES)) begin
            s_nxt.st = TLVPG_ERR;
          end else if (s_r.left == LEN_W'(WORD_BYTES)) begin
            s_nxt.st = TLVPG_DONE;
          end else begin
            s_nxt.st = TLVPG_HDR0;
          end
        end
      end
      TLVPG_HDR0: begin
        if (take && s_r.bcnt == ALIGN_MASK) begin
          // Reserved half ignored, type in upper half, low byte first
          s_nxt.hdr.typeId = wordNow[31:16];
          s_nxt.st = TLVPG_HDR1;
        end
      end
      TLVPG_HDR1: begin
        if (take && s_r.bcnt == ALIGN_MASK) begin
          s_nxt.hdr.valLen = len; // Length excludes padding
          s_nxt.valLeft = len;
          s_nxt.padLeft = pl - len;
          s_nxt.hdrVld = 1'b1;
          // Overrun check with wrap guard
          if (s_r.left < LEN_W'(HDR_BYTES) || pl > s_r.left - LEN_W'(HDR_BYTES)
              || pl < len) begin
            s_nxt.st = TLVPG_ERR;
          end else begin
            s_nxt.left = s_r.left - LEN_W'(HDR_BYTES) - pl;
            if (pl == '0) begin
              s_nxt.st = (s_r.left == LEN_W'(HDR_BYTES)) ? TLVPG_DONE : TLVPG_HDR0;
            end else begin
              s_nxt.st = TLVPG_VAL;
            end
          end
        end
      end
      TLVPG_VAL: begin
        if (take) begin
          // Value bytes pass through untouched, never re-parsed
          if (s_r.valLeft != '0) begin
            s_nxt.valVld = 1'b1;
            s_nxt.valByte = byteIn;
            s_nxt.valLast = (s_r.valLeft == LEN_W'(1));
            s_nxt.valLeft = s_r.valLeft - LEN_W'(1);
          end else begin
            s_nxt.padLeft = s_r.padLeft - LEN_W'(1);
          end
          if (s_r.valLeft + s_r.padLeft == LEN_W'(1)) begin
            // Next header follows directly stop at declared size
            s_nxt.st = (s_r.left == '0) ? TLVPG_DONE : TLVPG_HDR0;
          end
        end
      end
      TLVPG_DONE, TLVPG_ERR: begin
        if (start) begin
          s_nxt.st = TLVPG_IDLE;
        end
      end
      default: s_nxt.st = TLVPG_ERR;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hdrVld = s_r.hdrVld;
  assign hdr = s_r.hdr;
  assign valVld = s_r.valVld;
  assign valByte = s_r.valByte;
  assign valLast = s_r.valLast;
  assign ver = s_r.ver;
  assign verBad = s_r.verBad;
  assign busy = byteRdy;
  assign done = (s_r.st == TLVPG_DONE);
  assign err = (s_r.st == TLVPG_ERR);

  // ====================================================================
  // Partition gate
  tlvpg_part_gate #(.PID_W(PID_W), .NREQ(NREQ), .NCRT(NCRT)) u_gate (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .reqId(reqId),
    .reqVld(reqVld),
    .reqIsApp(reqIsApp),
    .crtId(crtId),
    .crtVld(crtVld),
    .secEnvDbgOff(secEnvDbgOff),
    .grant(grant)
  );

  // ====================================================================
  // Checks
  sequence s_hdrEnd;
    s_r.st == TLVPG_HDR1 && take && s_r.bcnt == ALIGN_MASK;
  endsequence

  property p_overrun;
    @(posedge ref_clk) disable iff (!arst_n)
    s_hdrEnd and (s_r.left < LEN_W'(HDR_BYTES)) |=> err;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_errStop;
    @(posedge ref_clk) disable iff (!arst_n)
    err && !start |=> err && !byteRdy && !valVld;
  endproperty
  a_errStop: assert property (p_errStop) else $error("parser ran after error");

  property p_hdrPulse;
    @(posedge ref_clk) disable iff (!arst_n)
    s_hdrEnd |=> hdrVld && hdr.valLen == $past(wordNow);
  endproperty
  a_hdrPulse: assert property (p_hdrPulse) else $error("length not little-endian");

  property p_type;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_HDR0 && take && s_r.bcnt == ALIGN_MASK
      |=> hdr.typeId == {$past(byteIn), $past(asmWord[31:24])};
  endproperty
  a_type: assert property (p_type) else $error("type field misplaced");

  property p_verZero;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_VER && take && s_r.bcnt == ALIGN_MASK && wordNow[7:0] == 8'h00 |=> verBad;
  endproperty
  a_verZero: assert property (p_verZero) else $error("major zero accepted");

  property p_verFirst;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_IDLE && start && hasVersion && seqSize[1:0] == 2'h0 |=> s_r.st == TLVPG_VER;
  endproperty
  a_verFirst: assert property (p_verFirst) else $error("version not read first");

  property p_align;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_IDLE && start && seqSize[1:0] != 2'h0 |=> err;
  endproperty
  a_align: assert property (p_align) else $error("unaligned size accepted");

  property p_recEnd;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_VAL && take && s_r.valLeft + s_r.padLeft == LEN_W'(1) && s_r.left != '0
      |=> s_r.st == TLVPG_HDR0 && s_r.bcnt == 2'h0;
  endproperty
  a_recEnd: assert property (p_recEnd) else $error("next record misplaced");

  property p_seqEnd;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_VAL && take && s_r.valLeft + s_r.padLeft == LEN_W'(1) && s_r.left == '0
      |=> done ##1 !byteRdy;
  endproperty
  a_seqEnd: assert property (p_seqEnd) else $error("walk did not stop");

  sequence s_valTake;
    s_r.st == TLVPG_VAL && take;
  endsequence

  property p_padHidden;
    @(posedge ref_clk) disable iff (!arst_n)
    s_valTake and (s_r.valLeft == '0) |=> !valVld;
  endproperty
  a_padHidden: assert property (p_padHidden) else $error("padding byte passed on");

  property p_valByte;
    @(posedge ref_clk) disable iff (!arst_n)
    s_valTake and (s_r.valLeft != '0) |=> valVld && valByte == $past(byteIn);
  endproperty
  a_valByte: assert property (p_valByte) else $error("value byte altered");

  property p_lastMark;
    @(posedge ref_clk) disable iff (!arst_n)
    s_valTake and (s_r.valLeft == LEN_W'(1)) |=> valLast;
  endproperty
  a_lastMark: assert property (p_lastMark) else $error("last value byte unmarked");

  property p_verWord;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_VER && take && s_r.bcnt == ALIGN_MASK
      |=> ver.major == $past(asmWord[15:8]) && ver.minor == $past(asmWord[23:16]);
  endproperty
  a_verWord: assert property (p_verWord) else $error("version bytes swapped");

  property p_hdrOrder;
    @(posedge ref_clk) disable iff (!arst_n)
    s_r.st == TLVPG_HDR0 && take && s_r.bcnt == ALIGN_MASK |=> s_r.st == TLVPG_HDR1;
  endproperty
  a_hdrOrder: assert property (p_hdrOrder) else $error("length word not after type");

  property p_zeroLen;
    @(posedge ref_clk) disable iff (!arst_n)
    s_hdrEnd and (wordNow == '0) and (s_r.left > LEN_W'(HDR_BYTES)) |=> s_r.st == TLVPG_HDR0;
  endproperty
  a_zeroLen: assert property (p_zeroLen) else $error("empty record not skipped");
endmodule
`default_nettype wire
